// ### hdl/dcs_pkg.sv
// constants for the disk controller status and ecc tap register bank
// assumes an 8-bit register bus with one-cycle read and write strobes
package dcs_pkg;
  // register offsets
  localparam logic [7:0] DCS_OFF_DMA_FLAG = 8'h55;
  localparam logic [7:0] DCS_OFF_SEQ_EVENT = 8'h56;
  localparam logic [7:0] DCS_OFF_SEQ_RUN = 8'h57;
  localparam logic [7:0] DCS_OFF_DRIVE_EVENT = 8'h58;
  localparam logic [7:0] DCS_OFF_RSVD_A = 8'h59;
  localparam logic [7:0] DCS_OFF_RSVD_B = 8'h5A;
  localparam logic [7:0] DCS_OFF_RSVD_C = 8'h5B;
  localparam logic [7:0] DCS_OFF_POLY = 8'h5F;
  // mode-4 selector codes that route polynomial register writes
  localparam logic [2:0] DCS_SEL_TAP = 3'h1;
  localparam logic [2:0] DCS_SEL_SIZE = 3'h2;
  // tap pointer ends
  localparam logic [2:0] DCS_PTR_MSB = 3'h7;
  localparam logic [2:0] DCS_PTR_LSB = 3'h0;
  // field positions inside the drive event bits
  localparam int DCS_DRV_MARK = 6;
  localparam int DCS_DRV_WFAULT = 5;
  localparam int DCS_DRV_SENSE_INPUT_TWO = 1;
  localparam int DCS_DRV_SENSE_INPUT_ONE = 0;
  // reset values
  localparam logic [7:0] DCS_RST_BYTE = 8'h00;
  localparam logic [63:0] DCS_RST_TAPS = 64'h0000_0000_0000_0000;
  localparam logic [5:0] DCS_RST_SIZE = 6'h3F;
  localparam logic [5:0] DCS_SIZE_MAX = 6'h3F;
endpackage : dcs_pkg

// ### hdl/dcs_status_regs.sv
// status registers, sequencer event flags and ecc polynomial programming
// assumes all inputs synchronous to sys_clk except the four sense pins
//
// What this block does
// - reset clears request bits, zero/overflow stay live
// - bits 7,6 show aux and main zero
// - bit 5 shows alu overflow; bit 4 reserved
// - low four bits mirror request latches
// - sequencer events set by sequencer, cleared by read
// - event 2 only sets its flag
// - events 1/0 lock file until release write
// - event 0 unlinks counters until relinked
// - run bit 7 shows sequencer busy
// - pc bits hold address before done instruction
// - data mark mismatch sets flag, fault point
// - sense two fall with enable sets write fault
// - crc error in read-after-write sets bit 4
// - sense four/three/two falls set bits 3-1
// - sense one any edge sets bit 0
// - addresses 59-5B reserved, read zero
// - tap writes load bytes msb first
// - tap pointer stops at lowest byte
// - mode-4 write returns pointer to msb
// - size masks unused high tap bits
// - size write holds length minus one
// - zero rise sets dma event, read clears
`timescale 1ns/100ps
`default_nettype none
module dcs_status_regs
  import dcs_pkg::*;
#(
  parameter int TAP_BYTES = 8
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic aux_zero,
  input wire logic main_zero,
  input wire logic alu_overflow,
  input wire logic [3:0] dma_req,
  input wire logic [2:0] sequencer_soft_events,
  input wire logic register_file_release,
  input wire logic counter_relink,
  input wire logic seq_busy,
  input wire logic seq_step,
  input wire logic [4:0] seq_pc,
  input wire logic done_event_microop,
  input wire logic data_mark_mismatch,
  input wire logic cmd_start,
  input wire logic raw_crc_error,
  input wire logic write_fault_en,
  input wire logic sense_input_one,
  input wire logic sense_input_two,
  input wire logic sense_input_three,
  input wire logic sense_input_four,
  input wire logic mode4_wr,
  input wire logic [2:0] mode4_sel,
  output logic fault_test_point,
  output logic dma_event,
  output logic file_locked,
  output logic counters_unlinked,
  output logic [TAP_BYTES*8-1:0] feedback_taps,
  output logic [5:0] poly_size
);

  // set dominates clear so a simultaneous event is kept
  function automatic logic [7:0] dcs_set_clr(input logic [7:0] cur,
                                             input logic [7:0] set,
                                             input logic [7:0] clr);
    return (cur & ~clr) | set;
  endfunction : dcs_set_clr

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0] req_r;
  logic [2:0] ev_r;
  logic [6:0] drv_r;
  logic lock_r;
  logic unlink_r;
  logic dma_ev_r;
  logic [1:0] zero_prev_r;
  logic [4:0] last_pc_r;
  logic [4:0] run_pc_r;
  logic [3:0] sns_s1_r;
  logic [3:0] sns_s2_r;
  logic [3:0] sns_prev_r;
  logic [2:0] prime_r;
  logic [TAP_BYTES-1:0][7:0] taps_r;
  logic [2:0] ptr_r;
  logic [5:0] size_r;
  logic [7:0] rdata_r;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire logic rd_dma = reg_rd && (reg_addr == DCS_OFF_DMA_FLAG);
  wire logic rd_ev = reg_rd && (reg_addr == DCS_OFF_SEQ_EVENT);
  wire logic rd_drv = reg_rd && (reg_addr == DCS_OFF_DRIVE_EVENT);
  wire logic wr_poly = reg_wr && (reg_addr == DCS_OFF_POLY);
  wire logic wr_tap = wr_poly && (mode4_sel == DCS_SEL_TAP);
  wire logic wr_size = wr_poly && (mode4_sel == DCS_SEL_SIZE);

  // ---------------------------------------------------------------
  // sense edge detection
  // ---------------------------------------------------------------
  // edges from synchronised samples
  wire logic [3:0] sns_pins = {sense_input_four, sense_input_three,
                               sense_input_two, sense_input_one};
  wire logic sns_ok = prime_r[2];
  wire logic [3:0] sns_fall = {4{sns_ok}} & sns_prev_r & ~sns_s2_r;
  wire logic [3:0] sns_rise = {4{sns_ok}} & ~sns_prev_r & sns_s2_r;

  // two-flop synchroniser, then a delayed copy
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sns_s1_r <= 4'h0;
      sns_s2_r <= 4'h0;
      sns_prev_r <= 4'h0;
      prime_r <= 3'h0;
    end
    else
    begin
      sns_s1_r <= sns_pins;
      sns_s2_r <= sns_s1_r;
      sns_prev_r <= sns_s2_r;
      prime_r <= {prime_r[1:0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // set and clear terms
  // ---------------------------------------------------------------
  // falls of sense four, three, two
  // mark flag cleared by command start or soft reset
  wire logic [6:0] drv_set = {data_mark_mismatch, sns_fall[1] & write_fault_en, raw_crc_error,
                              sns_fall[3:1], sns_fall[0] | sns_rise[0]};
  wire logic [6:0] drv_clr = {cmd_start | soft_rst, {6{rd_drv | soft_rst}}};
  wire logic [7:0] drv_nxt = dcs_set_clr({1'b0, drv_r}, {1'b0, drv_set},
                                         {1'b0, drv_clr});

  // events from sequencer, cleared by read or reset
  wire logic [7:0] ev_nxt = dcs_set_clr({5'h00, ev_r},
                                        {5'h00, sequencer_soft_events},
                                        {8{rd_ev | soft_rst}});

  // zero rise sets the dma event
  wire logic zero_rise = |({aux_zero, main_zero} & ~zero_prev_r);
  wire logic [7:0] dma_ev_nxt = dcs_set_clr({7'h00, dma_ev_r},
                                            {7'h00, zero_rise},
                                            {8{rd_dma | soft_rst}});

  // lock on event 1 or 0, release by one-write
  // only a one on release is seen here
  wire logic [7:0] lock_nxt = dcs_set_clr({7'h00, lock_r},
                                          {7'h00, |sequencer_soft_events[1:0]},
                                          {7'h00, register_file_release | soft_rst});

  // event 0 unlinks the offset counters
  wire logic [7:0] unlink_nxt = dcs_set_clr({7'h00, unlink_r},
                                            {7'h00, sequencer_soft_events[0]},
                                            {7'h00, counter_relink | soft_rst});

  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  // flags update after the read samples them
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      drv_r <= 7'h00;
      ev_r <= 3'h0;
      dma_ev_r <= 1'b0;
      lock_r <= 1'b0;
      unlink_r <= 1'b0;
      zero_prev_r <= 2'h0;
    end
    else
    begin
      drv_r <= drv_nxt[6:0];
      ev_r <= ev_nxt[2:0];
      dma_ev_r <= dma_ev_nxt[0];
      lock_r <= lock_nxt[0];
      unlink_r <= unlink_nxt[0];
      zero_prev_r <= {aux_zero, main_zero};
    end
  end

  // request mirror cleared by either reset
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      req_r <= 4'h0;
    else if (soft_rst)
      req_r <= 4'h0;
    else
      req_r <= dma_req;
  end

  // previous instruction address held at done
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      last_pc_r <= 5'h00;
      run_pc_r <= 5'h00;
    end
    else
    begin
      if (seq_step)
        last_pc_r <= seq_pc;
      if (done_event_microop)
        run_pc_r <= last_pc_r;
    end
  end

  // ---------------------------------------------------------------
  // ecc polynomial programming
  // ---------------------------------------------------------------
  // load at pointer, msb byte first
  // pointer parks on the lowest byte
  wire logic [2:0] ptr_step = (ptr_r == DCS_PTR_LSB) ? DCS_PTR_LSB : ptr_r - 3'h1;

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      taps_r <= DCS_RST_TAPS[TAP_BYTES*8-1:0];
      ptr_r <= DCS_PTR_MSB;
    end
    else
    begin
      if (wr_tap)
        taps_r[ptr_r] <= reg_wdata;
      if (mode4_wr)
        ptr_r <= DCS_PTR_MSB;
      else if (wr_tap)
        ptr_r <= ptr_step;
    end
  end

  // size holds polynomial length minus one
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      size_r <= DCS_RST_SIZE;
    else if (wr_size)
      size_r <= reg_wdata[5:0];
  end

  // unused high bits above the polynomial length drop out
  wire logic [63:0] len_mask = {64{1'b1}} >> (DCS_SIZE_MAX - size_r);
  assign feedback_taps = taps_r & len_mask[TAP_BYTES*8-1:0];
  assign poly_size = size_r;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // zero flags live in bits 7,6
  // overflow live in bit 5, bit 4 zero
  // busy in bit 7 of run status
  wire logic [7:0] dma_flag_val = {aux_zero, main_zero, alu_overflow, 1'b0, req_r};
  wire logic [7:0] ev_val = {ev_r, 5'h00};
  wire logic [7:0] run_val = {seq_busy, 2'h0, run_pc_r};
  wire logic [7:0] drv_val = {1'b0, drv_r};
  wire logic [7:0] poly_val = {2'h0, size_r};

  // reserved and unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb
  begin
    unique case (reg_addr)
      DCS_OFF_DMA_FLAG: rd_mux = dma_flag_val;
      DCS_OFF_SEQ_EVENT: rd_mux = ev_val;
      DCS_OFF_SEQ_RUN: rd_mux = run_val;
      DCS_OFF_DRIVE_EVENT: rd_mux = drv_val;
      DCS_OFF_POLY: rd_mux = poly_val;
      default: rd_mux = DCS_RST_BYTE;
    endcase
  end

  // read data captured before the clear lands
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_r <= DCS_RST_BYTE;
    else if (reg_rd)
      rdata_r <= rd_mux;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // fault point from mark or write fault
  assign fault_test_point = drv_r[DCS_DRV_MARK] | drv_r[DCS_DRV_WFAULT];
  assign reg_rdata = rdata_r;
  assign dma_event = dma_ev_r;
  assign file_locked = lock_r;
  assign counters_unlinked = unlink_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_req_mirror;
    !soft_rst |=> req_r == $past(dma_req);
  endproperty
  a_req_mirror: assert property (p_req_mirror)
    else $error("request mirror lags latch");
  // set wins over soft reset, so only a quiet cycle must clear requests, events and drive bits 5-0
  property p_soft_clear;
    soft_rst && drv_set == 7'h00 && sequencer_soft_events == 3'h0
      |=> req_r == 4'h0 && ev_r == 3'h0 && drv_r[5:0] == 6'h00;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("soft reset left flags set");
  property p_zero_read;
    rd_dma |=> reg_rdata[7:5] == $past({aux_zero, main_zero, alu_overflow});
  endproperty
  a_zero_read: assert property (p_zero_read)
    else $error("dma flag read wrong");
  property p_ev_clear;
    rd_ev && sequencer_soft_events == 3'h0 |=> ev_r == 3'h0;
  endproperty
  a_ev_clear: assert property (p_ev_clear)
    else $error("event read did not clear");
  // every drive or event set arriving with a clearing read must land
  property p_set_wins;
    rd_drv || rd_ev |=> (drv_r & $past(drv_set)) == $past(drv_set)
      && (ev_r & $past(sequencer_soft_events)) == $past(sequencer_soft_events);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost on clearing read");
  property p_lock;
    sequencer_soft_events[1] && !register_file_release |=> file_locked;
  endproperty
  a_lock: assert property (p_lock)
    else $error("file not locked");
  property p_unlink;
    sequencer_soft_events[0] |=> counters_unlinked;
  endproperty
  a_unlink: assert property (p_unlink)
    else $error("counters not unlinked");
  property p_mark_fault;
    data_mark_mismatch |=> fault_test_point;
  endproperty
  a_mark_fault: assert property (p_mark_fault)
    else $error("fault point idle after mismatch");
  property p_wfault;
    sns_fall[1] && !write_fault_en && !soft_rst && !drv_r[5] |=> !drv_r[5] && drv_r[1];
  endproperty
  a_wfault: assert property (p_wfault)
    else $error("write fault set without enable");
  property p_done_pc;
    done_event_microop |=> run_pc_r == $past(last_pc_r);
  endproperty
  a_done_pc: assert property (p_done_pc)
    else $error("done pc not captured");
  property p_ptr_park;
    wr_tap && !mode4_wr && ptr_r == DCS_PTR_LSB |=> ptr_r == DCS_PTR_LSB;
  endproperty
  a_ptr_park: assert property (p_ptr_park)
    else $error("tap pointer wrapped");
  property p_ptr_rewind;
    mode4_wr |=> ptr_r == DCS_PTR_MSB;
  endproperty
  a_ptr_rewind: assert property (p_ptr_rewind)
    else $error("tap pointer not rewound");
  property p_once;
    sns_fall[0] |=> !sns_fall[0];
  endproperty
  a_once: assert property (p_once)
    else $error("edge seen twice");
  c_tap_eight: cover property (wr_tap && ptr_r == DCS_PTR_LSB);
  c_read_set: cover property (rd_drv && |drv_set);
  c_release: cover property (file_locked ##1 register_file_release);

endmodule : dcs_status_regs
`default_nettype wire

// ### bench/dcs_host_model.sv
// local processor model driving the status register bus
// assumes reg_rdata is registered at the edge that takes reg_rd
`timescale 1ns/100ps
`default_nettype none
module dcs_host_model
(
  input wire logic sys_clk,
  output var logic [7:0] reg_addr,
  output var logic reg_rd,
  output var logic reg_wr,
  output var logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle bus from time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end

  // one write strobe held over its sampling edge
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;  // released data does not keep its value
    // one more edge so the written value stands on return
    @(posedge sys_clk);
  endtask : bus_write

  // one read strobe, data taken once the register has settled
  task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // read data stands from the edge after the strobe
    @(posedge sys_clk);
    d = reg_rdata;
  endtask : bus_read
endmodule : dcs_host_model
`default_nettype wire

// ### bench/dcs_status_regs_test.sv
// self-checking bench for the status and ecc tap register bank
// assumes dcs_host_model as bus master and the bench on other inputs
`timescale 1ns/100ps
`default_nettype none
module dcs_status_regs_test;
  import dcs_pkg::*;
  logic sys_clk, sys_rst, aux_zero, main_zero, alu_overflow;
  logic seq_busy, write_fault_en;
  logic sense_input_one, sense_input_two, sense_input_three, sense_input_four;
  logic [3:0] dma_req;
  logic [4:0] seq_pc;
  logic [2:0] mode4_sel;
  logic [11:0] pls;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, a;
  logic reg_rd, reg_wr, fault_test_point, dma_event, file_locked, counters_unlinked;
  logic [63:0] feedback_taps;
  logic [5:0] poly_size;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;

  // ----------------------------------------
  // design, host model and clock
  // ----------------------------------------
  dcs_status_regs dut (.sys_clk, .sys_rst, .soft_rst(pls[8]), .reg_addr, .reg_rd, .reg_wr,
    .reg_wdata, .reg_rdata, .aux_zero, .main_zero, .alu_overflow, .dma_req,
    .sequencer_soft_events(pls[11:9]), .register_file_release(pls[0]),
    .counter_relink(pls[1]), .seq_busy, .seq_step(pls[2]), .seq_pc,
    .done_event_microop(pls[3]), .data_mark_mismatch(pls[4]), .cmd_start(pls[5]),
    .raw_crc_error(pls[6]), .write_fault_en, .sense_input_one, .sense_input_two,
    .sense_input_three, .sense_input_four, .mode4_wr(pls[7]), .mode4_sel,
    .fault_test_point, .dma_event, .file_locked, .counters_unlinked, .feedback_taps,
    .poly_size);
  dcs_host_model host (.sys_clk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata);

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // read one register and compare it
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp, input string nm);
    host.bus_read(ad, d);
    check(nm, exp, d);
  endtask : rd

  // one-cycle pulse on the selected inputs, then one edge to settle
  task automatic pulse(input logic [11:0] p);
    @(posedge sys_clk);
    pls <= p;
    @(posedge sys_clk);
    pls <= 12'h000;
    @(posedge sys_clk);
  endtask : pulse

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : wt

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done

  // hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      test_done();
    end
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    {aux_zero, main_zero, alu_overflow, seq_busy, write_fault_en} = 5'h00;
    {sense_input_one, sense_input_two, sense_input_three, sense_input_four} = 4'hF;
    dma_req = 4'h0;
    seq_pc = 5'h00;
    mode4_sel = 3'h0;
    pls = 12'h000;
    wt(12);
    sys_rst <= 1'b0;
    wt(4);
    dma_req <= 4'hA;
    alu_overflow <= 1'b1;
    aux_zero <= 1'b1;
    wt(2);
    check("dma_event", 1'b1, dma_event);
    rd(DCS_OFF_DMA_FLAG, 8'hAA, "dma flags");
    check("dma_event", 1'b0, dma_event);
    $display("test dma flags done");
    pulse(12'h800);
    check("locked", 1'b0, file_locked);
    rd(DCS_OFF_SEQ_EVENT, 8'h80, "event2");
    rd(DCS_OFF_SEQ_EVENT, 8'h00, "event clr");
    pulse(12'h200);
    check("locked", 1'b1, file_locked);
    check("unlinked", 1'b1, counters_unlinked);
    rd(DCS_OFF_SEQ_EVENT, 8'h20, "event0");
    // no release pulse for three cycles, so the lock holds
    wt(3);
    check("still locked", 1'b1, file_locked);
    pulse(12'h001);
    check("locked", 1'b0, file_locked);
    check("unlinked", 1'b1, counters_unlinked);
    pulse(12'h002);
    check("unlinked", 1'b0, counters_unlinked);
    // event in the same cycle as the clearing read
    fork
      host.bus_read(DCS_OFF_SEQ_EVENT, d);
      pulse(12'h400);
    join
    check("event same cycle", 8'h00, d);
    rd(DCS_OFF_SEQ_EVENT, 8'h40, "event1 kept");
    pulse(12'h800);
    pulse(12'h100);
    rd(DCS_OFF_SEQ_EVENT, 8'h00, "soft reset");
    $display("test sequencer events done");
    seq_busy <= 1'b1;
    seq_pc <= 5'h0A;
    pulse(12'h004);
    seq_pc <= 5'h0B;
    pulse(12'h00C);
    rd(DCS_OFF_SEQ_RUN, 8'h8A, "run busy");
    seq_busy <= 1'b0;
    rd(DCS_OFF_SEQ_RUN, 8'h0A, "run done");
    $display("test run state done");
    write_fault_en <= 1'b1;
    sense_input_two <= 1'b0;
    wt(6);
    check("fault point", 1'b1, fault_test_point);
    rd(DCS_OFF_DRIVE_EVENT, 8'h22, "sense two fall");
    check("fault point", 1'b0, fault_test_point);
    rd(DCS_OFF_DRIVE_EVENT, 8'h00, "drive clr");
    sense_input_two <= 1'b1;
    wt(6);
    rd(DCS_OFF_DRIVE_EVENT, 8'h00, "sense two rise");
    write_fault_en <= 1'b0;
    sense_input_two <= 1'b0;
    wt(6);
    rd(DCS_OFF_DRIVE_EVENT, 8'h02, "fault disabled");
    sense_input_four <= 1'b0;
    sense_input_three <= 1'b0;
    wt(6);
    rd(DCS_OFF_DRIVE_EVENT, 8'h0C, "sense four three");
    sense_input_one <= 1'b0;
    wt(6);
    rd(DCS_OFF_DRIVE_EVENT, 8'h01, "sense one fall");
    sense_input_one <= 1'b1;
    wt(6);
    rd(DCS_OFF_DRIVE_EVENT, 8'h01, "sense one rise");
    rd(DCS_OFF_DRIVE_EVENT, 8'h00, "single set");
    pulse(12'h040);
    rd(DCS_OFF_DRIVE_EVENT, 8'h10, "crc error");
    pulse(12'h010);
    check("fault point", 1'b1, fault_test_point);
    rd(DCS_OFF_DRIVE_EVENT, 8'h40, "mark");
    rd(DCS_OFF_DRIVE_EVENT, 8'h40, "mark kept");
    pulse(12'h020);
    rd(DCS_OFF_DRIVE_EVENT, 8'h00, "mark cleared");
    $display("test drive events done");
    for (a = DCS_OFF_RSVD_A; a <= 8'h5C; a++)
    begin
      host.bus_write(a, 8'hFF);
      rd(a, 8'h00, "reserved");
    end
    $display("test reserved done");
    // tap loading, pointer reset by mode-4 write
    mode4_sel <= DCS_SEL_TAP;
    pulse(12'h080);
    for (int i = 1; i <= 9; i++)
      host.bus_write(DCS_OFF_POLY, 8'(i));
    check("taps", 64'h0102_0304_0506_0709, feedback_taps);
    pulse(12'h080);
    host.bus_write(DCS_OFF_POLY, 8'hAA);
    check("taps", 64'hAA02_0304_0506_0709, feedback_taps);
    mode4_sel <= DCS_SEL_SIZE;
    host.bus_write(DCS_OFF_POLY, 8'h0B);
    check("size", 6'h0B, poly_size);
    check("masked taps", 64'h0000_0000_0000_0709, feedback_taps);
    rd(DCS_OFF_POLY, 8'h0B, "size read");
    mode4_sel <= 3'h0;
    host.bus_write(DCS_OFF_POLY, 8'h05);
    check("size kept", 6'h0B, poly_size);
    $display("test polynomial done");
    test_done();
  end
endmodule : dcs_status_regs_test
`default_nettype wire
